// ==== test/mechanism_sensors.sv ====
// Behavioural model of the limit, home and sensor A switches
`timescale 1ns/1ps
module mechanism_sensors (
  input  wire logic hclk,
  input  wire logic fwd_req,
  input  wire logic rev_req,
  input  wire logic home_req,
  input  wire logic slot_req,
  output logic      forward_limit_input,
  output logic      reverse_limit_input,
  output logic      home_sensor_input,
  output logic      sensor_input_a
);
  // Switch levels follow the carriage one clock late, like a real contact
  always_ff @(posedge hclk) begin
    forward_limit_input <= fwd_req;
    reverse_limit_input <= rev_req;
    home_sensor_input   <= home_req;
    sensor_input_a      <= slot_req;
  end
endmodule

// ==== test/testbench.sv ====
// Register-level testbench of the homing and limit alarm monitor
`timescale 1ns/1ps
module testbench;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0, mode = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q, pos = 32'h0;
  logic        hreadyout, hresp, alm_n, mot, rdy, exc, fwd_ok, rev_ok, irq;
  logic [7:0]  code;
  logic [3:0]  blinks;
  logic        fl, rl, hs, sa, f_r = 0, r_r = 0, h_r = 0, a_r = 0, rst_pin = 0;
  logic        tim = 0, zero = 0, hom = 0, dir = 1, dec = 0, pf = 0, done = 0;
  logic        offs = 0, homed = 0;
  int          num_errors = 0, n_compared = 0;
  assign hready = hreadyout;
  // Clock at 25 MHz
  initial forever #20 hclk = ~hclk;
  mechanism_sensors i_mech (.hclk(hclk), .fwd_req(f_r), .rev_req(r_r), .home_req(h_r),
    .slot_req(a_r), .forward_limit_input(fl), .reverse_limit_input(rl),
    .home_sensor_input(hs), .sensor_input_a(sa));
  homing_limit_alarm_monitor i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .forward_limit_input(fl), .reverse_limit_input(rl), .home_sensor_input(hs),
    .sensor_input_a(sa), .alarm_reset_input(rst_pin), .step_timing_output(tim),
    .encoder_zero_output(zero), .homing_active(hom), .homing_mode(mode),
    .homing_dir_fwd(dir), .decelerating(dec), .preset_failed(pf), .homing_done(done),
    .offset_move(offs), .home_established(homed), .command_position(pos),
    .move_request(1'b1), .excite_request(1'b1), .alarm_output_active_low(alm_n),
    .motion_output(mot), .drive_command_ready(rdy), .motor_excited(exc),
    .alarm_code(code), .blink_count(blinks), .forward_allowed(fwd_ok),
    .reverse_allowed(rev_ok), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One AHB-Lite single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // Sensors and sequencer back to rest, then a reset operation by pin
  task automatic clear_all();
    @(posedge hclk);
    {f_r, r_r, h_r, a_r, hom, dec, pf, done, offs, homed} <= '0;
    mode <= 2'h0; dir <= 1; pos <= 32'h0; rst_pin <= 1;
    repeat (4) @(posedge hclk);
    rst_pin <= 0;
    repeat (4) @(negedge hclk);
    chk(code, 8'h00);
    chk(alm_n, 1'b1);
    @(posedge hclk);
  endtask
  // Bounded wait for an alarm, then code, blinks and output shutdown
  task automatic raise(input logic [7:0] c);
    int n;
    n = 0;
    while (alm_n !== 1'b0 && n < 12) begin
      @(negedge hclk);
      n++;
    end
    repeat (3) @(negedge hclk);
    chk(code, c);
    chk(blinks, alarm_monitor_pkg::BLINKS_ALARM);
    chk({alm_n, mot, rdy, exc}, 4'h0);
    clear_all();
    $display("TB: test for code %h done", c);
  endtask
  task automatic summarize();
    $display("TB: %0d compared, %0d errors", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests take
  initial begin
    #(40 * 20000);
    num_errors++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    bus(0, alarm_monitor_pkg::OFF_CTRL, 0);
    chk(q, alarm_monitor_pkg::CTRL_RST_VAL);
    chk(hresp, 1'b0);
    bus(0, 8'h24, 0);
    chk(q, 32'h0);
    // Hardware overtravel, escape after reset, interrupt raise and clear
    bus(1, alarm_monitor_pkg::OFF_IRQ_EN, 32'h1);
    bus(1, alarm_monitor_pkg::OFF_CTRL, 32'h32);
    repeat (4) @(negedge hclk);
    chk({mot, rdy, exc}, 3'h7);
    @(posedge hclk);
    f_r <= 1;
    repeat (6) @(negedge hclk);
    chk(code, alarm_monitor_pkg::CODE_HW_OT);
    chk(irq, 1'b1);
    bus(0, alarm_monitor_pkg::OFF_ALARM, 0);
    chk(q, 32'h0000_3766);
    bus(0, alarm_monitor_pkg::OFF_IRQ_STAT, 0);
    chk(q, 32'h1);
    bus(1, alarm_monitor_pkg::OFF_CTRL, 32'h72);
    repeat (4) @(negedge hclk);
    chk(code, 8'h00);
    chk({fwd_ok, rev_ok}, 2'h1);
    bus(1, alarm_monitor_pkg::OFF_IRQ_CLR, 32'h3);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b0);
    @(posedge hclk);
    f_r <= 0;
    bus(1, alarm_monitor_pkg::OFF_IRQ_EN, 32'h0);
    bus(1, alarm_monitor_pkg::OFF_CTRL, 32'h30);
    // Reversed limit while homing forward, with the interrupt masked
    hom <= 1; r_r <= 1;
    repeat (5) @(negedge hclk);
    chk(irq, 1'b0);
    raise(alarm_monitor_pkg::CODE_REV_LS);
    hom <= 1; mode <= alarm_monitor_pkg::HM_ONEWAY; dec <= 1; h_r <= 1;
    raise(alarm_monitor_pkg::CODE_HOMING);
    pf <= 1;
    raise(alarm_monitor_pkg::CODE_HOMING);
    // Three-sensor run: forward limit, turn round, reverse limit, no home
    hom <= 1; mode <= alarm_monitor_pkg::HM_THREE; f_r <= 1;
    repeat (5) @(posedge hclk);
    f_r <= 0;
    repeat (3) @(posedge hclk);
    dir <= 0; r_r <= 1;
    raise(alarm_monitor_pkg::CODE_NO_HOME);
    hom <= 1; done <= 1;
    @(posedge hclk);
    done <= 0;
    raise(alarm_monitor_pkg::CODE_SIGNAL);
    // Both detection options off: missing signals are not an alarm
    bus(1, alarm_monitor_pkg::OFF_CTRL, 32'h0);
    hom <= 1; done <= 1;
    @(posedge hclk);
    done <= 0;
    repeat (4) @(negedge hclk);
    chk(code, 8'h00);
    @(posedge hclk);
    hom <= 0; mode <= alarm_monitor_pkg::HM_ONEWAY; offs <= 1; f_r <= 1;
    raise(alarm_monitor_pkg::CODE_OFFSET);
    // Software limit at 100 with the lower limit out of reach
    bus(1, alarm_monitor_pkg::OFF_SOFT_HI, 32'd100);
    bus(1, alarm_monitor_pkg::OFF_SOFT_LO, 32'hffff_ff9c);
    bus(1, alarm_monitor_pkg::OFF_CTRL, 32'h0c);
    pos <= 32'd100;
    raise(alarm_monitor_pkg::CODE_SW_OT);
    bus(1, alarm_monitor_pkg::OFF_CTRL, 32'h0);
    bus(1, alarm_monitor_pkg::OFF_MECH_HI, 32'd200);
    bus(1, alarm_monitor_pkg::OFF_MECH_LO, 32'hffff_ff38);
    homed <= 1; pos <= 32'd200;
    raise(alarm_monitor_pkg::CODE_MECH_OT);
    summarize();
  end
endmodule

// ==== verilog/alarm_monitor_pkg.sv ====
// Constants and types shared by the homing and limit alarm monitor
package alarm_monitor_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_SOFT_HI  = 8'h04;
  localparam logic [7:0] OFF_SOFT_LO  = 8'h08;
  localparam logic [7:0] OFF_MECH_HI  = 8'h0c;
  localparam logic [7:0] OFF_MECH_LO  = 8'h10;
  localparam logic [7:0] OFF_ALARM    = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h1c;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h20;
  // Control register fields and reset value
  localparam int          CTRL_LIM_LSB  = 0;
  localparam int          CTRL_SOFT_LSB = 2;
  localparam int          CTRL_TZ_EN    = 4;
  localparam int          CTRL_SA_EN    = 5;
  localparam int          CTRL_RESET    = 6;
  localparam logic [31:0] CTRL_RST_VAL  = 32'h0000_0030;
  // Limit and software limit actions that raise an alarm
  localparam logic [1:0] ACT_IMM_ALARM = 2'h2;
  localparam logic [1:0] ACT_DEC_ALARM = 2'h3;
  // Homing mode encodings on homing_mode
  localparam logic [1:0] HM_TWO    = 2'h0;
  localparam logic [1:0] HM_THREE  = 2'h1;
  localparam logic [1:0] HM_ONEWAY = 2'h2;
  // Alarm codes and lamp blink count
  localparam logic [7:0] CODE_NONE    = 8'h00;
  localparam logic [7:0] CODE_REV_LS  = 8'h61;
  localparam logic [7:0] CODE_HOMING  = 8'h62;
  localparam logic [7:0] CODE_NO_HOME = 8'h63;
  localparam logic [7:0] CODE_SIGNAL  = 8'h64;
  localparam logic [7:0] CODE_HW_OT   = 8'h66;
  localparam logic [7:0] CODE_SW_OT   = 8'h67;
  localparam logic [7:0] CODE_OFFSET  = 8'h6a;
  localparam logic [7:0] CODE_MECH_OT = 8'h6d;
  localparam logic [3:0] BLINKS_ALARM = 4'h7;
  localparam logic [3:0] BLINKS_NONE  = 4'h0;
  // Alarm status register fields
  localparam int ST_BLINK_LSB = 8;
  localparam int ST_ACTIVE    = 12;
  localparam int ST_FWD_BLK   = 13;
  localparam int ST_REV_BLK   = 14;
  // Interrupt event bits
  localparam int IRQ_W      = 2;
  localparam int IRQ_RAISED = 0;
  localparam int IRQ_FREED  = 1;
  // Alarm state machine
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_ALARM = 2'b10
  } alarm_state_t;
endpackage

// ==== verilog/homing_limit_alarm_monitor.sv ====
// Homing, limit and overtravel alarm monitor with AHB-Lite registers
`timescale 1ns/1ps

// Summary of operation
// - Opposite limit during two/three-sensor homing: 61h, 7 blinks
// - Home passed while decelerating in one-way homing: 62h
// - Failed position preset after homing: 62h
// - Three-sensor homing never sees home between limits: 63h
// - No timing, zero or sensor A pulse during homing: 64h
// - Disabled detection option drops that signal from 64h
// - Limit action 2 or 3 and limit active outside homing: 66h
// - Software limit setting 2 or 3, limit reached: 67h
// - Limit active during homing offset move: 6Ah
// - Homed position reaches mechanism limit: 6Dh
// - After overtravel reset, allow motion away from limit
// - Any reset operation clears every alarm here
// - Alarm turns outputs off and de-excites motor
module homing_limit_alarm_monitor #(
  parameter int POS_W = 32
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [7:0]       haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire logic             forward_limit_input,
  input  wire logic             reverse_limit_input,
  input  wire logic             home_sensor_input,
  input  wire logic             sensor_input_a,
  input  wire logic             alarm_reset_input,
  input  wire logic             step_timing_output,
  input  wire logic             encoder_zero_output,
  input  wire logic             homing_active,
  input  wire logic [1:0]       homing_mode,
  input  wire logic             homing_dir_fwd,
  input  wire logic             decelerating,
  input  wire logic             preset_failed,
  input  wire logic             homing_done,
  input  wire logic             offset_move,
  input  wire logic             home_established,
  input  wire logic [POS_W-1:0] command_position,
  input  wire logic             move_request,
  input  wire logic             excite_request,
  output logic                  alarm_output_active_low,
  output logic                  motion_output,
  output logic                  drive_command_ready,
  output logic                  motor_excited,
  output logic [7:0]            alarm_code,
  output logic [3:0]            blink_count,
  output logic                  forward_allowed,
  output logic                  reverse_allowed,
  output logic                  irq
);

  // Position at or beyond a high or low bound
  function automatic logic [1:0] beyond(input logic [POS_W-1:0] p,
                                        input logic [POS_W-1:0] hi,
                                        input logic [POS_W-1:0] lo);
    beyond = {$signed(p) >= $signed(hi), $signed(p) <= $signed(lo)};
  endfunction

  // Local copies of package field positions, declared before any use
  localparam int CTRL_LIM_LSB  = alarm_monitor_pkg::CTRL_LIM_LSB;
  localparam int CTRL_SOFT_LSB = alarm_monitor_pkg::CTRL_SOFT_LSB;
  localparam int CTRL_RESET_B  = alarm_monitor_pkg::CTRL_RESET;
  localparam int IRQ_W         = alarm_monitor_pkg::IRQ_W;

  // Pin synchronisers: stage one is read only by stage two
  logic [4:0] sync1, sync2;
  logic       rst_prev;                       // Delayed reset pin for edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1    <= '0;
      sync2    <= '0;
      rst_prev <= 1'b0;
    end else begin
      sync1    <= {alarm_reset_input, sensor_input_a, home_sensor_input,
                   reverse_limit_input, forward_limit_input};
      sync2    <= sync1;
      rst_prev <= sync2[4];
    end
  end
  logic fwd, rev, home, sa;
  assign fwd  = sync2[0];
  assign rev  = sync2[1];
  assign home = sync2[2];
  assign sa   = sync2[3];

  // Bus registers
  logic [31:0]      ctrl;                     // Actions and detect enables
  logic [POS_W-1:0] soft_hi, soft_lo;         // Software limits
  logic [POS_W-1:0] mech_hi, mech_lo;         // Mechanism limits
  logic [IRQ_W-1:0] irq_stat, irq_en;
  logic             dp_wr;                    // Write data phase pending
  logic [7:0]       dp_addr;
  logic [31:0]      next_ctrl, next_hrdata;
  logic [POS_W-1:0] next_soft_hi, next_soft_lo, next_mech_hi, next_mech_lo;
  logic [IRQ_W-1:0] next_irq_en, irq_clr;
  logic             next_dp_wr, addr_ok, reset_op;
  logic [7:0]       next_dp_addr;
  logic [31:0]      status_word;

  // Monitor state
  alarm_monitor_pkg::alarm_state_t state, next_state;
  logic             fwd_blk, rev_blk;         // Escape-only directions
  logic             seen_home, hit_fwd, hit_rev, seen_tz, seen_sa;
  logic             next_fwd_blk, next_rev_blk, next_seen_home;
  logic             next_hit_fwd, next_hit_rev, next_seen_tz, next_seen_sa;
  logic [7:0]       next_code;
  logic [3:0]       next_blinks;
  logic             raise;                    // Alarm condition this cycle
  logic [7:0]       raise_code;
  logic             lim_on, soft_on, tz_en, sa_en, fwd_side, rev_side;
  logic [1:0]       soft_b, mech_b;

  assign lim_on  = ctrl[CTRL_LIM_LSB+:2] == alarm_monitor_pkg::ACT_IMM_ALARM ||
                   ctrl[CTRL_LIM_LSB+:2] == alarm_monitor_pkg::ACT_DEC_ALARM;
  assign soft_on = ctrl[CTRL_SOFT_LSB+:2] == alarm_monitor_pkg::ACT_IMM_ALARM ||
                   ctrl[CTRL_SOFT_LSB+:2] == alarm_monitor_pkg::ACT_DEC_ALARM;
  assign tz_en   = ctrl[alarm_monitor_pkg::CTRL_TZ_EN];
  assign sa_en   = ctrl[alarm_monitor_pkg::CTRL_SA_EN];
  assign soft_b  = beyond(command_position, soft_hi, soft_lo);
  assign mech_b  = beyond(command_position, mech_hi, mech_lo);
  // Any active source of overtravel on each side
  assign fwd_side = (lim_on & fwd) | (soft_on & soft_b[1]) |
                    (home_established & mech_b[1]);
  assign rev_side = (lim_on & rev) | (soft_on & soft_b[0]) |
                    (home_established & mech_b[0]);

  // Register reads are captured in the address phase, so hreadyout stays high
  assign status_word = {17'h0, rev_blk, fwd_blk, state == alarm_monitor_pkg::ST_ALARM,
                        blink_count, alarm_code};
  assign addr_ok     = hsel && hready && htrans[1];
  assign reset_op    = (sync2[4] && !rst_prev) ||
                       (dp_wr && dp_addr == alarm_monitor_pkg::OFF_CTRL &&
                        hwdata[alarm_monitor_pkg::CTRL_RESET]);
  always_comb begin
    next_ctrl    = ctrl;
    next_soft_hi = soft_hi;
    next_soft_lo = soft_lo;
    next_mech_hi = mech_hi;
    next_mech_lo = mech_lo;
    next_irq_en  = irq_en;
    irq_clr      = '0;
    next_dp_wr   = addr_ok && hwrite;
    next_dp_addr = addr_ok ? haddr : dp_addr;
    next_hrdata  = 32'h0;
    // Write data phase; the reset bit is a strobe and is not stored
    if (dp_wr) begin
      case (dp_addr)
        alarm_monitor_pkg::OFF_CTRL:    next_ctrl = hwdata & ~(32'h1 << CTRL_RESET_B);
        alarm_monitor_pkg::OFF_SOFT_HI: next_soft_hi = hwdata[POS_W-1:0];
        alarm_monitor_pkg::OFF_SOFT_LO: next_soft_lo = hwdata[POS_W-1:0];
        alarm_monitor_pkg::OFF_MECH_HI: next_mech_hi = hwdata[POS_W-1:0];
        alarm_monitor_pkg::OFF_MECH_LO: next_mech_lo = hwdata[POS_W-1:0];
        alarm_monitor_pkg::OFF_IRQ_EN:  next_irq_en = hwdata[IRQ_W-1:0];
        alarm_monitor_pkg::OFF_IRQ_CLR: irq_clr = hwdata[IRQ_W-1:0];
        default: ;                                  // Unmapped: ignored
      endcase
    end
    // Read address phase; unmapped reads return zero
    if (addr_ok && !hwrite) begin
      case (haddr)
        alarm_monitor_pkg::OFF_CTRL:     next_hrdata = ctrl;
        alarm_monitor_pkg::OFF_SOFT_HI:  next_hrdata = 32'(soft_hi);
        alarm_monitor_pkg::OFF_SOFT_LO:  next_hrdata = 32'(soft_lo);
        alarm_monitor_pkg::OFF_MECH_HI:  next_hrdata = 32'(mech_hi);
        alarm_monitor_pkg::OFF_MECH_LO:  next_hrdata = 32'(mech_lo);
        alarm_monitor_pkg::OFF_ALARM:    next_hrdata = status_word;
        alarm_monitor_pkg::OFF_IRQ_STAT: next_hrdata = 32'(irq_stat);
        alarm_monitor_pkg::OFF_IRQ_EN:   next_hrdata = 32'(irq_en);
        default:                         next_hrdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl      <= alarm_monitor_pkg::CTRL_RST_VAL;
      soft_hi   <= '0;
      soft_lo   <= '0;
      mech_hi   <= '0;
      mech_lo   <= '0;
      irq_en    <= '0;
      dp_wr     <= 1'b0;
      dp_addr   <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      soft_hi   <= next_soft_hi;
      soft_lo   <= next_soft_lo;
      mech_hi   <= next_mech_hi;
      mech_lo   <= next_mech_lo;
      irq_en    <= next_irq_en;
      dp_wr     <= next_dp_wr;
      dp_addr   <= next_dp_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;                      // Zero wait states
      hresp     <= 1'b0;                      // Always OKAY
    end
  end

  // Alarm detection in priority order; first match names the alarm
  always_comb begin
    raise      = 1'b1;
    raise_code = alarm_monitor_pkg::CODE_NONE;
    if (homing_active && (homing_mode == alarm_monitor_pkg::HM_TWO ||
        homing_mode == alarm_monitor_pkg::HM_THREE) &&
        (homing_dir_fwd ? rev : fwd))
      raise_code = alarm_monitor_pkg::CODE_REV_LS;
    else if (homing_active && homing_mode == alarm_monitor_pkg::HM_ONEWAY &&
             decelerating && home)
      raise_code = alarm_monitor_pkg::CODE_HOMING;
    else if (preset_failed)
      raise_code = alarm_monitor_pkg::CODE_HOMING;
    else if (homing_active && homing_mode == alarm_monitor_pkg::HM_THREE &&
             (hit_fwd | fwd) && (hit_rev | rev) && !(seen_home | home))
      raise_code = alarm_monitor_pkg::CODE_NO_HOME;
    else if (homing_done && (tz_en || sa_en) &&
             !(tz_en && (seen_tz | step_timing_output | encoder_zero_output)) &&
             !(sa_en && (seen_sa | sa)))
      raise_code = alarm_monitor_pkg::CODE_SIGNAL;
    else if (offset_move && (fwd || rev))
      raise_code = alarm_monitor_pkg::CODE_OFFSET;
    else if (!homing_active && lim_on && ((fwd && !fwd_blk) || (rev && !rev_blk)))
      raise_code = alarm_monitor_pkg::CODE_HW_OT;
    else if (soft_on && ((soft_b[1] && !fwd_blk) || (soft_b[0] && !rev_blk)))
      raise_code = alarm_monitor_pkg::CODE_SW_OT;
    else if (home_established && ((mech_b[1] && !fwd_blk) || (mech_b[0] && !rev_blk)))
      raise_code = alarm_monitor_pkg::CODE_MECH_OT;
    else
      raise = 1'b0;
  end

  // State, latched code and escape blocks
  always_comb begin
    next_state     = state;
    next_code      = alarm_code;
    next_blinks    = blink_count;
    next_fwd_blk   = fwd_blk && fwd_side;      // Freed once side is left
    next_rev_blk   = rev_blk && rev_side;
    next_seen_home = homing_active && (seen_home | home);
    next_hit_fwd   = homing_active && (hit_fwd | fwd);
    next_hit_rev   = homing_active && (hit_rev | rev);
    next_seen_tz   = homing_active && (seen_tz | step_timing_output | encoder_zero_output);
    next_seen_sa   = homing_active && (seen_sa | sa);
    case (state)
      alarm_monitor_pkg::ST_RUN: begin
        if (raise) begin
          next_state  = alarm_monitor_pkg::ST_ALARM;
          next_code   = raise_code;
          next_blinks = alarm_monitor_pkg::BLINKS_ALARM;
          if (raise_code == alarm_monitor_pkg::CODE_HW_OT ||
              raise_code == alarm_monitor_pkg::CODE_SW_OT ||
              raise_code == alarm_monitor_pkg::CODE_MECH_OT) begin
            next_fwd_blk = fwd_blk | fwd_side;
            next_rev_blk = rev_blk | rev_side;
          end
        end
      end
      alarm_monitor_pkg::ST_ALARM: begin
        // Blocks survive the reset so only the escape direction moves
        if (reset_op) begin
          next_state  = alarm_monitor_pkg::ST_RUN;
          next_code   = alarm_monitor_pkg::CODE_NONE;
          next_blinks = alarm_monitor_pkg::BLINKS_NONE;
        end
      end
      default: next_state = alarm_monitor_pkg::ST_ALARM;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= alarm_monitor_pkg::ST_RUN;
      alarm_code  <= 8'h00;
      blink_count <= 4'h0;
      fwd_blk     <= 1'b0;
      rev_blk     <= 1'b0;
      seen_home   <= 1'b0;
      hit_fwd     <= 1'b0;
      hit_rev     <= 1'b0;
      seen_tz     <= 1'b0;
      seen_sa     <= 1'b0;
    end else begin
      state       <= next_state;
      alarm_code  <= next_code;
      blink_count <= next_blinks;
      fwd_blk     <= next_fwd_blk;
      rev_blk     <= next_rev_blk;
      seen_home   <= next_seen_home;
      hit_fwd     <= next_hit_fwd;
      hit_rev     <= next_hit_rev;
      seen_tz     <= next_seen_tz;
      seen_sa     <= next_seen_sa;
    end
  end

  // Drive outputs and interrupts; alarm forces the motion, ready, excite and allowed outputs off at once
  logic             run_next;
  logic [IRQ_W-1:0] irq_ev, next_irq_stat;
  assign run_next = next_state == alarm_monitor_pkg::ST_RUN;
  always_comb begin
    irq_ev = '0;
    irq_ev[alarm_monitor_pkg::IRQ_RAISED] = state == alarm_monitor_pkg::ST_RUN && raise;
    irq_ev[alarm_monitor_pkg::IRQ_FREED]  = state == alarm_monitor_pkg::ST_ALARM && reset_op;
    next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;   // Set wins over clear
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_output_active_low <= 1'b1;
      motion_output           <= 1'b0;
      drive_command_ready     <= 1'b0;
      motor_excited           <= 1'b0;
      forward_allowed         <= 1'b0;
      reverse_allowed         <= 1'b0;
      irq_stat                <= '0;
      irq                     <= 1'b0;
    end else begin
      alarm_output_active_low <= run_next;
      motion_output           <= run_next && move_request;
      drive_command_ready     <= run_next && excite_request;
      motor_excited           <= run_next && excite_request;
      forward_allowed         <= run_next && !next_fwd_blk;
      reverse_allowed         <= run_next && !next_rev_blk;
      irq_stat                <= next_irq_stat;
      irq                     <= |(next_irq_stat & irq_en);
    end
  end

  // Checks on alarm behaviour
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_rev_ls;
    state == alarm_monitor_pkg::ST_RUN && homing_active &&
    homing_mode == alarm_monitor_pkg::HM_TWO && homing_dir_fwd && rev
    |=> alarm_code == 8'h61 && blink_count == 4'h7;
  endproperty
  a_rev_ls: assert property (p_rev_ls) else $error("reversed limit not flagged");

  property p_oneway;
    state == alarm_monitor_pkg::ST_RUN && homing_active && homing_mode == 2'h2 &&
    decelerating && home |=> alarm_code == 8'h62;
  endproperty
  a_oneway: assert property (p_oneway) else $error("home overrun not flagged");

  property p_preset;
    state == alarm_monitor_pkg::ST_RUN && !homing_active && preset_failed
    |=> alarm_code == 8'h62 && !alarm_output_active_low;
  endproperty
  a_preset: assert property (p_preset) else $error("preset failure not flagged");

  property p_sig_off;
    state == alarm_monitor_pkg::ST_RUN && !tz_en && !sa_en ##1 1'b1
    |-> alarm_code != 8'h64;
  endproperty
  a_sig_off: assert property (p_sig_off) else $error("disabled signal check fired");

  property p_hw_ot;
    state == alarm_monitor_pkg::ST_RUN && !homing_active && !offset_move &&
    !preset_failed && !homing_done && lim_on && fwd && !fwd_blk
    |=> alarm_code == 8'h66 && fwd_blk;
  endproperty
  a_hw_ot: assert property (p_hw_ot) else $error("hardware overtravel missed");

  property p_offset;
    state == alarm_monitor_pkg::ST_RUN && !homing_active && !preset_failed &&
    !homing_done && offset_move && (fwd || rev) |=> alarm_code == 8'h6a;
  endproperty
  a_offset: assert property (p_offset) else $error("offset limit not flagged");

  property p_reset;
    state == alarm_monitor_pkg::ST_ALARM && reset_op
    |=> alarm_output_active_low && alarm_code == 8'h00 && blink_count == 4'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear alarm");

  property p_stop;
    state == alarm_monitor_pkg::ST_RUN && raise
    |=> !alarm_output_active_low && !motion_output && !drive_command_ready && !motor_excited;
  endproperty
  a_stop: assert property (p_stop) else $error("outputs not dropped on alarm");

  property p_hold;
    state == alarm_monitor_pkg::ST_ALARM && !reset_op |=> $stable(alarm_code) && blink_count == 4'h7;
  endproperty
  a_hold: assert property (p_hold) else $error("latched code changed");

  property p_escape;
    state == alarm_monitor_pkg::ST_ALARM && reset_op && fwd_blk && fwd_side && !rev_side
    |=> !forward_allowed && reverse_allowed;
  endproperty
  a_escape: assert property (p_escape) else $error("escape direction wrong");

endmodule
